// >>> hdl/irbg_core.sv
// irbg_core: game-state logic for infrared vehicle combat
`timescale 1ns/1ps
`default_nettype none
module irbg_core
    import irbg_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic setup_btn_i,
    input wire logic ir_hit_i,
    input wire logic ir_valid_code_i,
    input wire logic fire_req_i,
    output logic fire_o,
    output logic drive_enable_o,
    output logic control_enable_o,
    output logic [7:0] speed_limit_o,
    output logic slight_damage_o,
    output logic sensor_led_o,
    output irbg_sound_req_t sound_o,
    output irbg_setting_t setting_o
);
    typedef struct packed {
        logic [1:0] btn_sync;
        logic [1:0] hit_sync;
        logic [1:0] code_sync;
        logic btn_prev;
        logic hit_prev;
        logic [23:0] prescale;
        irbg_setting_t setting;
        irbg_phase_t phase;
        logic [3:0] hits;
        logic booted;
        logic [3:0] blink_left;
        logic led;
        logic fire;
        irbg_sound_req_t sound;
        logic drive_en;
        logic ctrl_en;
        logic [7:0] speed;
        logic slight;
    } irbg_state_t;
    irbg_state_t st, next_st;

    irbg_profile_t prof;
    logic tick, btn_rise, hit_rise, hit_ok, combat_on;
    logic stop_busy, reload_busy, reload_done;
    logic phase_done, blink_busy, blink_done;
    logic start_stop, start_reload, start_phase, start_blink;
    logic [4:0] phase_secs;

    // profile lookup; the off setting reuses light figures but never acts
    always_comb begin
        unique case (st.setting)
            IRBG_TEST: prof = PROF_TEST;
            IRBG_MEDIUM: prof = PROF_MEDIUM;
            IRBG_HEAVY: prof = PROF_HEAVY;
            default: prof = PROF_LIGHT;
        endcase
    end

    // edge detect on the second synchroniser stage only
    assign tick = (st.prescale == SEC_LAST);
    assign btn_rise = st.btn_sync[1] && !st.btn_prev;
    assign hit_rise = st.hit_sync[1] && !st.hit_prev;
    assign combat_on = (st.setting != IRBG_OFF);
    // test setting skips the code check
    assign hit_ok = hit_rise && combat_on && st.phase == IRBG_ALIVE
        && (st.setting == IRBG_TEST || st.code_sync[1]);

    // timer triggers
    assign start_stop = hit_ok;
    assign start_reload = fire_req_i && !reload_busy && combat_on && st.ctrl_en;
    assign start_phase = (hit_ok && st.hits + 4'h1 >= prof.kill_hits)
        || (phase_done && st.phase == IRBG_DESTROYED);
    assign phase_secs = (st.phase == IRBG_DESTROYED) ? prof.invuln_s : prof.destroy_s;
    assign start_blink = (!st.booted || (blink_done && st.blink_left != 4'h0));

    irbg_sec_timer u_stop (.clock_i(clock_i), .arst_n_i(arst_n_i), .tick_i(tick),
        .start_i(start_stop), .secs_i(HIT_STOP_S), .busy_o(stop_busy), .done_o());
    irbg_sec_timer u_reload (.clock_i(clock_i), .arst_n_i(arst_n_i), .tick_i(tick),
        .start_i(start_reload), .secs_i(prof.reload_s), .busy_o(reload_busy),
        .done_o(reload_done));
    irbg_sec_timer u_phase (.clock_i(clock_i), .arst_n_i(arst_n_i), .tick_i(tick),
        .start_i(start_phase), .secs_i(phase_secs), .busy_o(),
        .done_o(phase_done));
    irbg_sec_timer u_blink (.clock_i(clock_i), .arst_n_i(arst_n_i), .tick_i(tick),
        .start_i(start_blink), .secs_i(BLINK_S), .busy_o(blink_busy),
        .done_o(blink_done));

    // main next-state logic
    always_comb begin
        next_st = st;
        next_st.btn_sync = {st.btn_sync[0], setup_btn_i};
        next_st.hit_sync = {st.hit_sync[0], ir_hit_i};
        next_st.code_sync = {st.code_sync[0], ir_valid_code_i};
        next_st.btn_prev = st.btn_sync[1];
        next_st.hit_prev = st.hit_sync[1];
        next_st.prescale = tick ? 24'h000000 : st.prescale + 24'h000001;
        next_st.sound = '0;
        next_st.fire = start_reload;
        next_st.booted = 1'b1;
        // power-up blinks: each blink is two seconds, off then on
        if (!st.booted) begin
            next_st.blink_left = {prof.blinks, 1'b0};
        end else if (blink_done && st.blink_left != 4'h0) begin
            next_st.blink_left = st.blink_left - 4'h1;
            next_st.led = st.blink_left[0] ? 1'b0 : 1'b1;
        end
        if (st.blink_left == 4'h0 && !blink_busy) begin
            next_st.led = (st.phase == IRBG_DESTROYED);
        end
        if (reload_done && combat_on) begin
            next_st.sound = '{1'b1, IRBG_SND_RELOADED, st.setting};
        end
        // phase sequencing after destruction
        if (phase_done && st.phase == IRBG_DESTROYED) begin
            next_st.phase = IRBG_INVULN;
            next_st.hits = 4'h0;
            next_st.sound = '{1'b1, IRBG_SND_FANFARE, st.setting};
        end else if (phase_done && st.phase == IRBG_INVULN) begin
            next_st.phase = IRBG_ALIVE;
        end
        if (hit_ok) begin
            next_st.hits = st.hits + 4'h1;
            if (st.hits + 4'h1 >= prof.kill_hits) begin
                next_st.phase = IRBG_DESTROYED;
                next_st.sound = '{1'b1, IRBG_SND_EXPLODE, st.setting};
            end else begin
                next_st.sound = '{1'b1, IRBG_SND_IMPACT, st.setting};
            end
        end
        // a setup press outranks game sounds and re-arms the game
        if (btn_rise) begin
            unique case (st.setting)
                IRBG_LIGHT: next_st.setting = IRBG_MEDIUM;
                IRBG_MEDIUM: next_st.setting = IRBG_HEAVY;
                IRBG_HEAVY: next_st.setting = IRBG_TEST;
                IRBG_TEST: next_st.setting = IRBG_OFF;
                default: next_st.setting = IRBG_LIGHT;
            endcase
            next_st.sound = '{1'b1, IRBG_SND_ANNOUNCE, next_st.setting};
            next_st.phase = IRBG_ALIVE;
            next_st.hits = 4'h0;
        end
        // outputs from the game state
        next_st.ctrl_en = !(next_st.phase == IRBG_DESTROYED) || !combat_on;
        next_st.drive_en = next_st.ctrl_en && !(stop_busy && combat_on)
            && !start_stop;
        next_st.slight = combat_on && next_st.hits >= 4'h1;
        next_st.speed = (combat_on && next_st.hits >= prof.slow_hits)
            ? SPEED_SLOW : SPEED_FULL;
    end

    // state register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '{setting: IRBG_LIGHT, phase: IRBG_ALIVE, sound: '0,
                speed: SPEED_FULL, drive_en: 1'b1, ctrl_en: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign fire_o = st.fire;
    assign drive_enable_o = st.drive_en;
    assign control_enable_o = st.ctrl_en;
    assign speed_limit_o = st.speed;
    assign slight_damage_o = st.slight;
    assign sensor_led_o = st.led;
    assign sound_o = st.sound;
    assign setting_o = st.setting;

    sequence press_s;
        btn_rise;
    endsequence
    sequence announce_s;
        sound_o.valid && sound_o.code == IRBG_SND_ANNOUNCE;
    endsequence

    setup_announce_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        press_s |=> announce_s) else $error("press without announcement");
    setup_advance_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        btn_rise && st.setting == IRBG_TEST |=> st.setting == IRBG_OFF)
        else $error("setting did not advance");
    // watch the ports, not the internal gate, so a broken enable path is caught
    off_ignores_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !combat_on |=> drive_enable_o && control_enable_o && !slight_damage_o && !fire_o
        && !(sound_o.valid && sound_o.code != IRBG_SND_ANNOUNCE))
        else $error("combat behaviour while off");
    test_any_ir_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        hit_rise && st.setting == IRBG_TEST && st.phase == IRBG_ALIVE && !btn_rise
        |=> sound_o.valid && !drive_enable_o)
        else $error("test setting dropped a pulse");
    hit_stops_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        hit_ok && !btn_rise |=> !drive_enable_o ##0 sound_o.valid)
        else $error("hit did not stop vehicle");
    kill_blocks_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        hit_ok && !btn_rise && st.hits + 4'h1 >= prof.kill_hits
        |=> sound_o.code == IRBG_SND_EXPLODE ##0 !control_enable_o)
        else $error("destruction not signalled");
    slow_speed_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        combat_on && st.hits >= prof.slow_hits && !btn_rise && !$past(btn_rise)
        && !(phase_done && st.phase == IRBG_DESTROYED)
        |=> speed_limit_o == SPEED_SLOW) else $error("speed not reduced");
    // a press right after resurrection may legally return to alive, so look one cycle only
    reborn_clear_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        phase_done && st.phase == IRBG_DESTROYED && !btn_rise
        |=> sound_o.valid && sound_o.code == IRBG_SND_FANFARE && st.hits == 4'h0
        && st.phase == IRBG_INVULN)
        else $error("resurrection wrong");
    guard_no_count_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        st.phase != IRBG_ALIVE && !btn_rise && !phase_done |=> st.hits == $past(st.hits))
        else $error("hit counted while protected");
    reload_block_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        reload_busy |=> !fire_o) else $error("fired during reload");
endmodule : irbg_core
`default_nettype wire

// >>> hdl/irbg_pkg.sv
// irbg_pkg: constants and types for the ir battle game logic
package irbg_pkg;
    // clock rate and one-second prescale
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SEC_CYCLES = CLK_HZ;
    localparam logic [23:0] SEC_LAST = 24'(SEC_CYCLES - 1);
    // stop time after a hit, in seconds
    localparam logic [4:0] HIT_STOP_S = 5'h02;
    // reduced speed limit while slowed, full limit otherwise
    localparam logic [7:0] SPEED_FULL = 8'hFF;
    localparam logic [7:0] SPEED_SLOW = 8'h80;
    // blink pulse half period in seconds
    localparam logic [4:0] BLINK_S = 5'h01;

    typedef enum logic [2:0] {
        IRBG_LIGHT, IRBG_MEDIUM, IRBG_HEAVY, IRBG_TEST, IRBG_OFF
    } irbg_setting_t;

    typedef enum logic [2:0] {
        IRBG_SND_NONE, IRBG_SND_ANNOUNCE, IRBG_SND_IMPACT, IRBG_SND_EXPLODE,
        IRBG_SND_FANFARE, IRBG_SND_RELOADED
    } irbg_sound_t;

    typedef enum logic [1:0] {
        IRBG_ALIVE, IRBG_DESTROYED, IRBG_INVULN
    } irbg_phase_t;

    // per-setting figures; times in seconds
    typedef struct packed {
        logic [3:0] slow_hits;
        logic [3:0] kill_hits;
        logic [4:0] destroy_s;
        logic [4:0] reload_s;
        logic [4:0] invuln_s;
        logic [2:0] blinks;
    } irbg_profile_t;

    localparam irbg_profile_t PROF_TEST = '{4'h3, 4'h6, 5'h03, 5'h02, 5'h05, 3'h4};
    localparam irbg_profile_t PROF_LIGHT = '{4'h2, 4'h3, 5'h03, 5'h0F, 5'h0F, 3'h1};
    localparam irbg_profile_t PROF_MEDIUM = '{4'h4, 4'h6, 5'h05, 5'h0C, 5'h0F, 3'h2};
    localparam irbg_profile_t PROF_HEAVY = '{4'h5, 4'h9, 5'h09, 5'h0A, 5'h0F, 3'h3};

    // sound request carried to the player
    typedef struct packed {
        logic valid;
        irbg_sound_t code;
        irbg_setting_t setting;
    } irbg_sound_req_t;
endpackage : irbg_pkg

// >>> hdl/irbg_sec_timer.sv
// irbg_sec_timer: restartable down-counter in whole seconds
`timescale 1ns/1ps
`default_nettype none
module irbg_sec_timer
    import irbg_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic [4:0] secs_i,
    output logic busy_o,
    output logic done_o
);
    typedef struct packed {
        logic [4:0] left;
        logic done;
    } irbg_tmr_t;
    irbg_tmr_t st, next_st;

    // restart wins over counting so a repeated trigger starts afresh
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (start_i) begin
            next_st.left = secs_i;
        end else if (tick_i && st.left != 5'h00) begin
            next_st.left = st.left - 5'h01;
            next_st.done = (st.left == 5'h01);
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = (st.left != 5'h00);
    assign done_o = st.done;

    tmr_load_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        start_i |=> st.left == $past(secs_i))
        else $error("timer did not load");
endmodule : irbg_sec_timer
`default_nettype wire

// >>> test/irbg_sensor_model.sv
// irbg_sensor_model: infrared hit sensor and barrel transmitter partner
`timescale 1ns/1ps
`default_nettype none
module irbg_sensor_model (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic hit_req_i,
    input wire logic code_ok_i,
    input wire logic fire_i,
    output logic ir_hit_o,
    output logic ir_valid_code_o,
    output logic [7:0] shots_o
);
    logic [3:0] pulse_cnt;
    logic idle_flip;
    // a burst of ir light lasts four cycles, then five dark cycles before the next may start
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_cnt <= 4'h0;
            idle_flip <= 1'b0;
            shots_o <= 8'h00;
        end else begin
            idle_flip <= ~idle_flip;
            if (fire_i) begin
                shots_o <= shots_o + 8'h01; // the transmitter counts every released shot
            end
            if (pulse_cnt != 4'h0) begin
                pulse_cnt <= pulse_cnt - 4'h1;
            end else if (hit_req_i) begin
                pulse_cnt <= 4'h8;
            end
        end
    end
    // the code line means nothing in the dark, so it wanders instead of holding its last value
    assign ir_hit_o = (pulse_cnt > 4'h4);
    assign ir_valid_code_o = ir_hit_o ? code_ok_i : idle_flip;
endmodule : irbg_sensor_model
`default_nettype wire

// >>> test/irbg_core_tb.sv
// irbg_core_tb: self-checking bench for the ir battle game logic
`timescale 1ns/1ps
`default_nettype none
module irbg_core_tb
    import irbg_pkg::*;
;
    logic clock_i, arst_n_i, setup_btn_i, fire_req_i, hit_req, code_ok;
    logic ir_hit, ir_code, fire_o, drive_enable_o, control_enable_o, slight_damage_o, led;
    logic [7:0] speed_limit_o, shots;
    irbg_sound_req_t sound_o;
    irbg_setting_t setting_o, got_set;
    irbg_sound_t got_code;
    int got_n, mismatches, comparisons;

    irbg_core dut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .setup_btn_i(setup_btn_i),
        .ir_hit_i(ir_hit), .ir_valid_code_i(ir_code), .fire_req_i(fire_req_i),
        .fire_o(fire_o), .drive_enable_o(drive_enable_o),
        .control_enable_o(control_enable_o), .speed_limit_o(speed_limit_o),
        .slight_damage_o(slight_damage_o), .sensor_led_o(led), .sound_o(sound_o),
        .setting_o(setting_o)
    );
    irbg_sensor_model sensor (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .hit_req_i(hit_req), .code_ok_i(code_ok),
        .fire_i(fire_o), .ir_hit_o(ir_hit), .ir_valid_code_o(ir_code), .shots_o(shots)
    );

    // 10 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // records the last sound pulse and how many cycles sound was valid
    task automatic watch(input int cycles);
        got_code = IRBG_SND_NONE;
        got_n = 0;
        repeat (cycles) begin
            @(posedge clock_i);
            #1;
            if (sound_o.valid === 1'b1) begin
                got_code = sound_o.code;
                got_set = sound_o.setting;
                got_n++;
            end
        end
    endtask : watch

    // button held through the sync delay so the press is seen once
    task automatic press(input irbg_setting_t exp);
        @(posedge clock_i);
        setup_btn_i <= 1'b1;
        watch(8);
        check(8'(got_code), 8'(IRBG_SND_ANNOUNCE));
        check(8'(got_set), 8'(exp));
        check(8'(got_n), 8'h01);
        check(8'(setting_o), 8'(exp));
        @(posedge clock_i);
        setup_btn_i <= 1'b0;
        watch(4);
    endtask : press

    task automatic strike(input logic ok);
        @(posedge clock_i);
        hit_req <= 1'b1;
        code_ok <= ok;
        @(posedge clock_i);
        hit_req <= 1'b0;
        watch(14);
    endtask : strike

    task automatic fire_try(input logic [7:0] exp);
        @(posedge clock_i);
        fire_req_i <= 1'b1;
        @(posedge clock_i);
        fire_req_i <= 1'b0;
        watch(5);
        check(shots, exp);
    endtask : fire_try

    // hits up to the kill count, then one more that must be ignored
    task automatic damage(input int slow, input int kill, input logic ok);
        for (int k = 1; k <= kill; k++) begin
            strike(ok);
            if (k == kill) begin
                check(8'(got_code), 8'(IRBG_SND_EXPLODE));
                check(8'(control_enable_o), 8'h00);
            end else begin
                check(8'(got_code), 8'(IRBG_SND_IMPACT));
                check(8'(drive_enable_o), 8'h00);
                check(speed_limit_o, (k >= slow) ? SPEED_SLOW : SPEED_FULL);
                check(8'(slight_damage_o), 8'h01);
            end
        end
        strike(ok);
        check(8'(got_code), 8'(IRBG_SND_NONE));
        fire_try(8'h00);
        $display("test damage %0d/%0d done", slow, kill);
    endtask : damage

    task automatic t_off;
        press(IRBG_OFF);
        strike(1'b1);
        check(8'(got_code), 8'(IRBG_SND_NONE));
        check(8'(drive_enable_o), 8'h01);
        check(8'(control_enable_o), 8'h01);
        check(8'(slight_damage_o), 8'h00);
        fire_try(8'h00);
        $display("test off done");
    endtask : t_off

    // outside the test setting a stray pulse is no hit; one shot, then reload blocks
    task automatic t_reload;
        press(IRBG_LIGHT);
        strike(1'b0);
        check(8'(got_code), 8'(IRBG_SND_NONE));
        check(8'(slight_damage_o), 8'h00);
        fire_try(8'h01);
        fire_try(8'h01);
        check(8'(got_code), 8'(IRBG_SND_NONE));
        $display("test reload done");
    endtask : t_reload

    initial begin
        mismatches = 0;
        comparisons = 0;
        arst_n_i = 1'b0;
        setup_btn_i = 1'b0;
        fire_req_i = 1'b0;
        hit_req = 1'b0;
        code_ok = 1'b0;
        repeat (12) @(posedge clock_i);
        #1;
        check(8'(setting_o), 8'(IRBG_LIGHT));
        check(speed_limit_o, SPEED_FULL);
        @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        press(IRBG_MEDIUM);
        press(IRBG_HEAVY);
        press(IRBG_TEST);
        press(IRBG_OFF);
        press(IRBG_LIGHT);
        // no hit yet: vehicle free, undamaged, led still in its first dark second
        check(8'(drive_enable_o), 8'h01);
        check(8'(control_enable_o), 8'h01);
        check(8'(slight_damage_o), 8'h00);
        check(8'(led), 8'h00);
        $display("test setup cycle done");
        damage(2, 3, 1'b1);
        press(IRBG_MEDIUM);
        damage(4, 6, 1'b1);
        press(IRBG_HEAVY);
        damage(5, 9, 1'b1);
        press(IRBG_TEST);
        damage(3, 6, 1'b0);
        t_off();
        t_reload();
        close_out();
    end

    // watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clock_i);
        mismatches++;
        close_out();
    end
endmodule : irbg_core_tb
`default_nettype wire
